// ===== apoi_cap.sv
// capture end: makes the sample strobe, latches words and hands them to the core domain
`timescale 1ns/100ps
`default_nettype none
module apoi_cap
  import apoi_pkg::*;
#(
  parameter int unsigned DATA_W   = APOI_DATA_W,
  parameter int unsigned DEPTH    = APOI_FIFO_DEPTH,
  parameter int unsigned HALF_DIV = APOI_HALF_DIV
) (
  // clock, reset, enable
  input  wire logic              i_core_clk,
  input  wire logic              i_sys_rst,
  input  wire logic              i_ce,
  // link
  apoi_link_if.cap               link,
  // control
  input  wire logic              i_run,
  input  wire logic              i_offset_binary,
  input  wire logic              i_drive_enable,
  // sample stream out
  output logic                   o_valid,
  output logic      [DATA_W-1:0] o_word,
  output logic                   o_overflow,
  input  wire logic              i_ready,
  output logic                   o_dropped
);
  typedef enum logic [0:0] {APOI_IDLE, APOI_RUN} apoi_state_e;
  localparam int unsigned DW = $clog2(HALF_DIV + 1);
  apoi_state_e        state_q;
  logic [DW-1:0]      div_q;
  logic               strobe_q;
  logic [2:0]         os_sync_q;
  logic [DATA_W-1:0]  cap_word_q;
  logic               cap_ovf_q;
  logic               in_valid;
  logic               in_ready;
  logic               drop_q;
  logic [DATA_W:0]    link_cap_q;
  // equal halves from one divider keep the duty at 50%; the divider
  // must stay below the rate ceiling and above the droop floor [RULE2] [RULE3] [RULE4]
  wire div_end = (div_q == DW'(HALF_DIV - 1));
  always_ff @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      state_q  <= APOI_IDLE;
      div_q    <= '0;
      strobe_q <= 1'b0;
    end
    else if (i_ce)
    begin
      case (state_q)
        APOI_IDLE:
        begin
          div_q    <= '0;
          strobe_q <= 1'b0;
          if (i_run)
            state_q <= APOI_RUN;
        end
        APOI_RUN:
        begin
          div_q <= div_end ? '0 : div_q + 1'b1;
          if (div_end)
            strobe_q <= ~strobe_q; // [RULE1] [RULE5]
          if (!i_run && div_end && strobe_q)
            state_q <= APOI_IDLE;
        end
        default: state_q <= APOI_IDLE;
      endcase
    end
  end
  assign link.sample_strobe = strobe_q;
  assign link.format_select = i_offset_binary;
  // enable is a level meant for idle periods only [RULE13]
  assign link.output_enable = i_drive_enable;
  // capture timed from the returned strobe, never our own [RULE11]
  always_ff @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      os_sync_q <= '0;
    else if (i_ce)
      os_sync_q <= {os_sync_q[1:0], link.output_strobe_o & link.output_strobe_oe};
  end
  // link domain: the pair is latched on the returned strobe rise and then holds a
  // whole strobe period, so the core side may read it once the rise is synced [RULE10]
  always_ff @(posedge link.output_strobe_o or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      link_cap_q <= '0;
    else
      link_cap_q <= {link.range_overflow_o, link.word_o}; // [RULE10]
  end
  // rise seen two core cycles after the pin; limitation: the strobe period must
  // outlast the synchroniser, or the held pair moves while the core reads it
  wire os_edge = os_sync_q[2] == 1'b0 && os_sync_q[1] == 1'b1;
  always_ff @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      cap_word_q <= '0;
      cap_ovf_q  <= 1'b0;
      in_valid   <= 1'b0;
      drop_q     <= 1'b0;
    end
    else if (i_ce)
    begin
      in_valid <= os_edge;
      drop_q   <= in_valid && !in_ready;
      if (os_edge)
      begin
        cap_word_q <= link_cap_q[DATA_W-1:0]; // [RULE10]
        cap_ovf_q  <= link_cap_q[DATA_W];
      end
    end
  end
  assign o_dropped = drop_q;
  apoi_fifo #(
    .WIDTH(DATA_W + 1),
    .DEPTH(DEPTH)
  ) u_fifo (
    .i_core_clk (i_core_clk),
    .i_sys_rst  (i_sys_rst),
    .i_ce       (i_ce),
    .i_in_valid (in_valid),
    .i_in_data  ({cap_ovf_q, cap_word_q}),
    .o_in_ready (in_ready),
    .o_out_valid(o_valid),
    .o_out_data ({o_overflow, o_word}),
    .i_out_ready(i_ready)
  );
endmodule
`default_nettype wire

// ===== apoi_pkg.sv
// shared constants for the parallel converter output link
package apoi_pkg;
  localparam int unsigned APOI_DATA_W      = 14;
  localparam int unsigned APOI_LATENCY     = 5;
  localparam int unsigned APOI_FIFO_DEPTH  = 8;
  localparam int unsigned APOI_CORE_HZ     = 10_000_000;
  localparam int unsigned APOI_MAX_RATE_HZ = 65_000_000;
  localparam int unsigned APOI_MIN_RATE_HZ = 1_000_000;
  localparam int unsigned APOI_MIN_HALF_PS = 7300;
  // strobe divider: half period in core cycles, never below one
  localparam int unsigned APOI_HALF_DIV    = 2;
  // longest half period allowed at the minimum rate, in core cycles (rounded down)
  localparam int unsigned APOI_MAX_HALF_CYC = APOI_CORE_HZ / (2 * APOI_MIN_RATE_HZ);
  localparam logic [APOI_DATA_W-1:0] APOI_SIGN_BIT = 14'h2000;
  localparam logic [APOI_DATA_W-1:0] APOI_ZERO     = 14'h0000;
endpackage

// ===== apoi_link_if.sv
// link carrier between the converter end and the capture end
`timescale 1ns/100ps
`default_nettype none
interface apoi_link_if;
  import apoi_pkg::*;
  logic                   sample_strobe;
  logic                   format_select;
  logic                   output_enable;
  logic [APOI_DATA_W-1:0] word_o;
  logic [APOI_DATA_W-1:0] word_oe;
  logic                   range_overflow_o;
  logic                   range_overflow_oe;
  logic                   output_strobe_o;
  logic                   output_strobe_oe;
  modport conv (input sample_strobe, format_select, output_enable,
                output word_o, word_oe, range_overflow_o, range_overflow_oe, output_strobe_o, output_strobe_oe);
  modport cap  (output sample_strobe, format_select, output_enable,
                input word_o, word_oe, range_overflow_o, range_overflow_oe, output_strobe_o, output_strobe_oe);
endinterface
`default_nettype wire

// ===== apoi_fifo.sv
// parameterised valid/ready fifo
`timescale 1ns/100ps
`default_nettype none
module apoi_fifo #(
  parameter int unsigned WIDTH = 15,
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input  wire logic             i_core_clk,
  input  wire logic             i_sys_rst,
  input  wire logic             i_ce,
  // fill side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // drain side
  output logic                  o_out_valid,
  output logic      [WIDTH-1:0] o_out_data,
  input  wire logic             i_out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  wire              push = i_ce && i_in_valid && o_in_ready;
  wire              pop  = i_ce && o_out_valid && i_out_ready;
  assign o_in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data  = mem_q[rd_q];
  always_ff @(posedge i_core_clk)
  begin
    if (push)
      mem_q[wr_q] <= i_in_data;
  end
  always_ff @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      if (pop)
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// ===== apoi_conv.sv
// converter end: pipelined sample path clocked by the sample strobe
//
// Functional notes
// RULE1 - strobe source keeps rate at most 65Msps
// RULE2 - duty cycle 50% within 5% at maximum
// RULE3 - each strobe phase lasts at least 7.3ns
// RULE4 - slower rates may skew duty, phases still long
// RULE5 - strobe source keeps rate at least 1Msps
// RULE6 - format high offset binary, low two's complement
// RULE7 - overflow high when sample out of range
// RULE8 - output strobe is delayed copy of sample strobe; the model copies it with no delay
// RULE9 - word and overflow change after output strobe falls
// RULE10 - receiver captures on output strobe rising edge
// RULE11 - receiver times capture from output strobe
// RULE12 - output enable low floats every output
// RULE13 - output enable toggled only for long idle
// RULE14 - sample on strobe rise, track while low
// RULE15 - 14-bit word, fixed parameterised latency
`timescale 1ns/100ps
`default_nettype none
module apoi_conv
  import apoi_pkg::*;
#(
  parameter int unsigned DATA_W  = APOI_DATA_W,
  parameter int unsigned LATENCY = APOI_LATENCY
) (
  // link
  apoi_link_if.conv           link,
  // analog stand-in: signed sample and range flag, tracked while strobe low
  input  wire logic              i_sys_rst,
  input  wire logic [DATA_W-1:0] i_analog_code,
  input  wire logic              i_analog_over
);
  logic [DATA_W-1:0] pipe_q [LATENCY];
  logic              ovf_q  [LATENCY];
  logic [DATA_W-1:0] word_q;
  logic              ovf_out_q;
  logic              strobe_dly;
  // the sample is frozen on the rising strobe edge; inputs only track while low [RULE14]
  always_ff @(posedge link.sample_strobe or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      for (int i = 0; i < LATENCY; i++)
      begin
        pipe_q[i] <= '0;
        ovf_q[i]  <= 1'b0;
      end
    end
    else
    begin
      pipe_q[0] <= i_analog_code;
      ovf_q[0]  <= i_analog_over; // [RULE7]
      for (int i = 1; i < LATENCY; i++)
      begin
        pipe_q[i] <= pipe_q[i-1]; // [RULE15]
        ovf_q[i]  <= ovf_q[i-1];
      end
    end
  end
  // outputs move on the falling edge so the rising edge sees stable data [RULE9]
  always_ff @(negedge link.sample_strobe or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      word_q    <= '0;
      ovf_out_q <= 1'b0;
    end
    else
    begin
      // offset binary flips the sign bit of the two's complement code [RULE6]
      word_q    <= link.format_select ? (pipe_q[LATENCY-1] ^ APOI_SIGN_BIT) : pipe_q[LATENCY-1];
      ovf_out_q <= ovf_q[LATENCY-1]; // [RULE7]
    end
  end
  // a buffered copy; real delay is in the pad, not modelled here [RULE8]
  assign strobe_dly = link.sample_strobe;
  // tri-state through enables; only the capture end's strobe sync masks a value with its enable [RULE12]
  assign link.word_o            = word_q;
  assign link.word_oe           = {DATA_W{link.output_enable}};
  assign link.range_overflow_o  = ovf_out_q;
  assign link.range_overflow_oe = link.output_enable;
  assign link.output_strobe_o   = strobe_dly; // [RULE8]
  assign link.output_strobe_oe  = link.output_enable;
endmodule
`default_nettype wire

// ===== apoi_link_checker.sv
// link checker: strobe shape, output timing, coding and float
`timescale 1ns/100ps
`default_nettype none
module apoi_link_checker
  import apoi_pkg::*;
(
  // core domain
  input wire logic                   i_core_clk,
  input wire logic                   i_sys_rst,
  // link
  input wire logic                   sample_strobe,
  input wire logic                   format_select,
  input wire logic                   output_enable,
  input wire logic [APOI_DATA_W-1:0] word_o,
  input wire logic [APOI_DATA_W-1:0] word_oe,
  input wire logic                   range_overflow_o,
  input wire logic                   range_overflow_oe,
  input wire logic                   output_strobe_o,
  input wire logic                   output_strobe_oe,
  // converter inputs
  input wire logic [APOI_DATA_W-1:0] i_analog_code,
  input wire logic                   i_analog_over
);
  // rises since reset: words stay reset values until the pipeline refills
  logic [2:0] rise_q;
  always_ff @(posedge sample_strobe or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      rise_q <= 3'h0;
    else if (rise_q != 3'h7)
      rise_q <= rise_q + 3'h1;
  end
  sequence high_then_low;
    sample_strobe ##1 !sample_strobe [*2];
  endsequence
  strobe_shape_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    $rose(sample_strobe) |=> high_then_low) else $error("strobe phase length wrong");
  strobe_copy_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    output_enable |-> output_strobe_o == sample_strobe) else $error("output strobe not a copy");
  float_all_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    !output_enable |-> word_oe == '0 && !range_overflow_oe && !output_strobe_oe) else $error("output driven");
  word_change_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    $changed(word_o) |-> $fell(output_strobe_o)) else $error("word moved off strobe fall");
  flag_change_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    $changed(range_overflow_o) |-> $fell(output_strobe_o)) else $error("flag moved off strobe fall");
  word_delay_a: assert property (@(posedge sample_strobe) disable iff (i_sys_rst)
    rise_q >= 3'h6 |-> word_o[12:0] == $past(i_analog_code[12:0], 5)) else $error("word latency wrong");
  sign_format_a: assert property (@(posedge sample_strobe) disable iff (i_sys_rst)
    rise_q >= 3'h6 && format_select == $past(format_select, 5)
    |-> word_o[13] == ($past(i_analog_code[13], 5) ^ format_select)) else $error("sign coding wrong");
  flag_delay_a: assert property (@(posedge sample_strobe) disable iff (i_sys_rst)
    rise_q >= 3'h6 |-> range_overflow_o == $past(i_analog_over, 5)) else $error("overflow flag wrong");
endmodule
`default_nettype wire

// ===== apoi_tb.sv
// bench: both link ends, streams in both codings, float and buffer overflow
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin mismatches++; \
  $display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module apoi_tb
  import apoi_pkg::*;
();
  logic                   core_clk = 1'h0;
  logic                   sys_rst = 1'h1;
  logic                   run = 1'h0, fmt = 1'h0, drv_en = 1'h1, ready = 1'h1, over = 1'h0, locked = 1'h0;
  logic [APOI_DATA_W-1:0] code = '0, o_word;
  logic                   o_valid, o_ovf, o_drop;
  logic [APOI_DATA_W:0]   q[$];
  logic [APOI_DATA_W:0]   ex;
  int                     mismatches = 0, compares = 0, pops = 0, drops = 0;
  apoi_link_if link ();
  apoi_conv apoi_conv_inst (.link(link.conv), .i_sys_rst(sys_rst), .i_analog_code(code), .i_analog_over(over));
  apoi_cap apoi_cap_inst (.i_core_clk(core_clk), .i_sys_rst(sys_rst), .i_ce(1'h1), .link(link.cap), .i_run(run),
    .i_offset_binary(fmt), .i_drive_enable(drv_en), .o_valid(o_valid), .o_word(o_word), .o_overflow(o_ovf),
    .i_ready(ready), .o_dropped(o_drop));
  apoi_link_checker apoi_link_checker_inst (.i_core_clk(core_clk), .i_sys_rst(sys_rst),
    .sample_strobe(link.sample_strobe), .format_select(link.format_select), .output_enable(link.output_enable),
    .word_o(link.word_o), .word_oe(link.word_oe), .range_overflow_o(link.range_overflow_o),
    .range_overflow_oe(link.range_overflow_oe), .output_strobe_o(link.output_strobe_o),
    .output_strobe_oe(link.output_strobe_oe), .i_analog_code(code), .i_analog_over(over));
  initial
  begin
    forever #50 core_clk = ~core_clk;
  end
  // monitor: reset words are skipped until the first noted sample shows up
  always @(posedge core_clk)
  begin
    if (link.output_enable === 1'h1)
      `CHK("strobe_copy", link.sample_strobe, link.output_strobe_o)
    if (o_drop === 1'h1)
      drops++;
    if (o_valid === 1'h1 && ready === 1'h1)
    begin
      pops++;
      if (!locked && q.size() > 0 && {o_ovf, o_word} === q[0])
        locked = 1'h1;
      if (locked && q.size() > 0)
      begin
        ex = q.pop_front();
        `CHK("sample", ex, {o_ovf, o_word})
      end
    end
  end
  task automatic tally_and_finish;
    $display("counts: %0d compares, %0d mismatches", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic give_up;
    mismatches++;
    $display("[FAIL] wait exp done got timeout");
    tally_and_finish();
  endtask
  // enable and coding change only while held in reset and idle
  task automatic restart(input logic f, input logic en);
    sys_rst <= 1'h1;
    run <= 1'h0;
    fmt <= f;
    drv_en <= en;
    ready <= 1'h1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'h0;
    q.delete();
    locked = 1'h0;
    drops = 0;
    @(posedge core_clk);
    run <= 1'h1;
  endtask
  task automatic wait_strobe(input logic lvl);
    int n;
    for (n = 0; n < 40 && link.sample_strobe !== lvl; n++) @(posedge core_clk);
    if (n == 40)
      give_up();
  endtask
  // codes change only in the high phase, so never at a sampling rise
  task automatic stream(input int cnt, input logic live);
    logic [APOI_DATA_W-1:0] c;
    logic                   o;
    repeat (cnt)
    begin
      wait_strobe(1'h1);
      c = APOI_DATA_W'($urandom);
      o = 1'($urandom);
      code <= c;
      over <= o;
      ready <= live && ($urandom % 4 != 0);
      if (live)
        q.push_back({o, fmt ? c ^ APOI_SIGN_BIT : c});
      wait_strobe(1'h0);
    end
  endtask
  task automatic drain;
    int n;
    ready <= 1'h1;
    for (n = 0; n < 400 && (q.size() > 0 || o_valid === 1'h1); n++) @(posedge core_clk);
    if (n == 400)
      give_up();
  endtask
  initial
  begin
    void'($urandom(32'hB7D4));
    restart(1'h0, 1'h1);
    stream(24, 1'h1);
    drain();
    $display("test twos_complement done");
    restart(1'h1, 1'h1);
    stream(24, 1'h1);
    drain();
    $display("test offset_binary done");
    restart(1'h0, 1'h0);
    repeat (12) @(posedge core_clk);
    `CHK("word_oe", 14'h0000, link.word_oe)
    `CHK("flag_oe", 1'h0, link.range_overflow_oe)
    `CHK("strobe_oe", 1'h0, link.output_strobe_oe)
    $display("test float done");
    restart(1'h0, 1'h1);
    stream(16, 1'h0);
    `CHK("strobe_oe", 1'h1, link.output_strobe_oe)
    run <= 1'h0;
    repeat (20) @(posedge core_clk);
    pops = 0;
    drain();
    `CHK("drained", APOI_FIFO_DEPTH, pops)
    `CHK("dropped", 1'h1, drops != 0)
    $display("test buffer_full done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
